// ===== logic/ialb_defs.svh
/*
  constants for the input activity leaky bucket: register offsets, field
  positions, reset values and timing counts.
  assumes a 10 mhz reference clock and byte-wide registers on a 32-bit bus.
*/
`ifndef IALB_DEFS_SVH
`define IALB_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets (printed index, byte address is four times it)
// ----------------------------------------------------------------------
`define IALB_IDX_LEAK_RATE   8'h53
`define IALB_IDX_STATUS      8'h60
`define IALB_IDX_MASK        8'h61
`define IALB_IDX_LEVEL       8'h62

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define IALB_RATE_LSB        0
`define IALB_RATE_MSB        1
`define IALB_LEAK_RATE_RST   8'h01
`define IALB_ST_FILL         0
`define IALB_ST_DRAIN        1
`define IALB_ST_ZERO         2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define IALB_CLK_HZ          10000000
`define IALB_MON_MS          128
`define IALB_MON_CYC         ((`IALB_CLK_HZ / 1000) * `IALB_MON_MS)

`endif

// ===== logic/ialb_pkg.sv
/*
  types for the input activity leaky bucket.
  assumes ialb_defs.svh is on the include path.
*/
package ialb_pkg;
  typedef logic [7:0] ialb_level_t;
  typedef logic [1:0] ialb_rate_t;
  typedef logic [7:0] ialb_reg_t;
endpackage : ialb_pkg

// ===== logic/ialb_drain_timer.sv
/*
  drain timer: counts fault-free monitoring cycles and pulses when the
  programmed span of 1, 2, 4 or 8 cycles has passed.
  assumes tick is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
module ialb_drain_timer
  import ialb_pkg::*;
(
  input  wire logic               REF_CLK,
  input  wire logic               RESETN,
  input  wire logic               TICK,
  input  wire logic               FAULT,
  input  wire ialb_pkg::ialb_rate_t RATE,
  output logic                    DRAIN
);
  logic [2:0] span_cnt;
  logic [2:0] span_last;
  logic       span_done;

  // span of 2**rate cycles, last count is span - 1
  assign span_last = 3'((4'h1 << RATE) - 4'h1);   // see (RULE3)
  // a shortened span after a rate change drains at once, never wraps
  assign span_done = TICK && !FAULT && (span_cnt >= span_last);
  assign DRAIN     = span_done;                    // see (RULE2)

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      span_cnt <= 3'h0;
    else if (TICK && (FAULT || span_done))
      span_cnt <= 3'h0;                            // see (RULE5)
    else if (TICK)
      span_cnt <= span_cnt + 3'h1;
  end

  drain_span_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (TICK && FAULT) |=> (span_cnt == 3'h0))        // see (RULE5)
    else $error("drain timer not restarted by fault");
endmodule : ialb_drain_timer

// ===== logic/ialb_top.sv
/*
  leaky-bucket accumulator for one input activity monitor, with its
  decay-rate register, status, mask and interrupt, on avalon-mm.
  assumes the fault flag comes from another clock domain and is held
  for the monitoring cycle it describes.
*/
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`include "ialb_defs.svh"

// Behaviour
// (RULE1) fault cycle adds one to bucket, up to 0xff
// (RULE2) each clean span of 2**rate cycles subtracts one
// (RULE3) rate code selects 128/256/512/1024 ms drain
// (RULE4) rate register resets to 0x01, upper unused
// (RULE5) saturate at zero; fault restarts drain timer
module ialb_top
  import ialb_pkg::*;
#(
  parameter int MON_CYC = `IALB_MON_CYC
)
(
  input  wire logic        REF_CLK,
  input  wire logic        RESETN,
  input  wire logic        FAULT_IN,
  input  wire logic [9:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             IRQ
);
  import ialb_pkg::*;

  // ----------------------------------------------------------------------
  // input synchroniser and monitoring cycle tick
  // ----------------------------------------------------------------------
  logic        fault_m;
  logic        fault_s;
  logic        fault_seen;
  logic [20:0] mon_cnt;
  logic        tick;

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      fault_m <= 1'b0;
      fault_s <= 1'b0;
    end
    else
    begin
      fault_m <= FAULT_IN;
      fault_s <= fault_m;
    end
  end

  assign tick = (mon_cnt == 21'(MON_CYC - 1));

  // any fault seen during the cycle marks it as a fault cycle
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      mon_cnt    <= 21'h0;
      fault_seen <= 1'b0;
    end
    else
    begin
      mon_cnt    <= tick ? 21'h0 : mon_cnt + 21'h1;
      fault_seen <= tick ? 1'b0 : (fault_seen | fault_s);
    end
  end

  wire cycle_fault = fault_seen | fault_s;

  // ----------------------------------------------------------------------
  // registers and bus decode
  // ----------------------------------------------------------------------
  ialb_reg_t   leak_rate;
  ialb_reg_t   irq_status;
  ialb_reg_t   irq_mask;
  ialb_level_t level;
  logic        rd_pending;

  wire [7:0] word_idx  = AVS_ADDRESS[9:2];
  wire       lane0     = AVS_BYTEENABLE[0];
  wire       wr_rate   = AVS_WRITE && lane0 &&
                         (word_idx == `IALB_IDX_LEAK_RATE);
  wire       wr_status = AVS_WRITE && lane0 &&
                         (word_idx == `IALB_IDX_STATUS);
  wire       wr_mask   = AVS_WRITE && lane0 &&
                         (word_idx == `IALB_IDX_MASK);
  wire [7:0] wdata     = AVS_WRITEDATA[7:0];

  // reads take one wait cycle, writes none
  assign AVS_WAITREQUEST = AVS_READ && !rd_pending;

  wire [7:0] rd_mux =
    (word_idx == `IALB_IDX_LEAK_RATE) ? leak_rate  :
    (word_idx == `IALB_IDX_STATUS)    ? irq_status :
    (word_idx == `IALB_IDX_MASK)      ? irq_mask   :
    (word_idx == `IALB_IDX_LEVEL)     ? level      : 8'h00;

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rd_pending   <= 1'b0;
      AVS_READDATA <= 32'h0;
    end
    else
    begin
      rd_pending <= AVS_READ && !rd_pending;
      if (AVS_READ && !rd_pending)
        AVS_READDATA <= {24'h0, rd_mux};
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      leak_rate <= `IALB_LEAK_RATE_RST;            // see (RULE4)
      irq_mask  <= 8'h00;
    end
    else
    begin
      if (wr_rate)
        leak_rate <= {6'h0, wdata[1:0]};           // see (RULE4)
      if (wr_mask)
        irq_mask <= {5'h0, wdata[2:0]};
    end
  end

  // ----------------------------------------------------------------------
  // bucket
  // ----------------------------------------------------------------------
  logic drain;
  wire  fill     = tick && cycle_fault;
  wire  at_max   = (level == 8'hff);
  wire  do_inc   = fill && !at_max;                // see (RULE1)
  wire  do_dec   = drain && (level != 8'h00);      // see (RULE5)

  ialb_drain_timer u_drain_timer (
    .REF_CLK (REF_CLK),
    .RESETN  (RESETN),
    .TICK    (tick),
    .FAULT   (cycle_fault),
    .RATE    (leak_rate[`IALB_RATE_MSB:`IALB_RATE_LSB]), // see (RULE3)
    .DRAIN   (drain)
  );

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      level <= 8'h00;
    else if (do_inc)
      level <= level + 8'h01;                      // see (RULE1)
    else if (do_dec)
      level <= level - 8'h01;                      // see (RULE2)
  end

  // ----------------------------------------------------------------------
  // interrupts: set wins over write-one-to-clear
  // ----------------------------------------------------------------------
  wire [7:0] ev_set = {5'h0, do_dec && (level == 8'h01), do_dec, fill};
  wire [7:0] next_status = (irq_status & ~(wr_status ? wdata : 8'h00))
                           | ev_set;

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      irq_status <= 8'h00;
    else
      irq_status <= next_status;
  end

  assign IRQ = |(irq_status & irq_mask);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence clean_tick_s;
    tick && !cycle_fault;
  endsequence

  bucket_fill_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (tick && cycle_fault && level != 8'hff) |=>
      (level == $past(level) + 8'h01))                 // see (RULE1)
    else $error("fault cycle did not add one");

  bucket_drain_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (drain && level != 8'h00 && !fill) |=>
      (level == $past(level) - 8'h01))                 // see (RULE2)
    else $error("drain did not subtract one");

  drain_rate00_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (clean_tick_s and (leak_rate[1:0] == 2'h0)) |-> drain) // see (RULE3)
    else $error("rate 00 must drain every cycle");

  no_drain_fault_a: assert property (@(posedge REF_CLK)
    disable iff (!RESETN)
    (tick && cycle_fault) |-> !drain)                  // see (RULE5)
    else $error("drain during fault cycle");

  zero_floor_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    ($past(level) == 8'h00 && !$past(fill)) |-> (level == 8'h00)) // see (RULE5)
    else $error("bucket wrapped below zero");

  rate_upper_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    leak_rate[7:2] == 6'h0)                            // see (RULE4)
    else $error("unused rate bits set");

  only_tick_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    !tick |=> (level == $past(level)))                 // see (RULE1)
    else $error("bucket moved off monitoring tick");

  status_sticky_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (irq_status[0] && !wr_status) |=> irq_status[0])
    else $error("status bit lost without clear");

  zero_status_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (do_dec && level == 8'h01) |=> (irq_status[2] && level == 8'h00)) // see (RULE5)
    else $error("zero event not recorded");
endmodule : ialb_top

// ===== test/ialb_bench.sv
/*
  self-checking bench for ialb_top: register reset values, rate codes,
  refused accesses, mask, status and a second reset.
  assumes ialb_defs.svh on the include path; the monitoring cycle is
  shortened to 16 clocks so fill and drain are reached.
*/
`timescale 1ns/1ps
`include "ialb_defs.svh"
module ialb_bench;
  import ialb_pkg::*;
  logic        REF_CLK = 1'b0;
  logic        RESETN = 1'b0;
  logic        FAULT_IN = 1'b0;
  logic [9:0]  AVS_ADDRESS = 10'h000;
  logic        AVS_READ = 1'b0;
  logic        AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0]  AVS_BYTEENABLE = 4'h0;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic        IRQ;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [31:0] rd;

  ialb_top #(.MON_CYC(16)) u_dut (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .FAULT_IN(FAULT_IN),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ)
  );

  // ----------------------------------------------------------------
  // clock and timeout
  // ----------------------------------------------------------------
  always #50 REF_CLK = ~REF_CLK;

  always @(posedge REF_CLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task conclude;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
    @(posedge REF_CLK);
    AVS_ADDRESS <= {idx, 2'b00};
    AVS_WRITEDATA <= {24'h0, d};
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= 1'b1;
    do @(posedge REF_CLK); while (AVS_WAITREQUEST !== 1'b0);
    AVS_WRITE <= 1'b0;
  endtask : wr

  task wait_tick;
    @(posedge REF_CLK iff (u_dut.tick === 1'b1));
  endtask : wait_tick

  task rdr(input logic [7:0] idx, output logic [31:0] d);
    @(posedge REF_CLK);
    AVS_ADDRESS <= {idx, 2'b00};
    AVS_READ <= 1'b1;
    do @(posedge REF_CLK); while (AVS_WAITREQUEST !== 1'b0);
    d = AVS_READDATA;
    AVS_READ <= 1'b0;
  endtask : rdr

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset_values;
    rdr(`IALB_IDX_LEAK_RATE, rd);
    check(rd, {24'h0, `IALB_LEAK_RATE_RST});
    rdr(`IALB_IDX_STATUS, rd);
    check(rd, 32'h0);
    rdr(`IALB_IDX_MASK, rd);
    check(rd, 32'h0);
    rdr(`IALB_IDX_LEVEL, rd);
    check(rd, 32'h0);
    check({31'h0, IRQ}, 32'h0);
  endtask : t_reset_values

  task t_rate_codes;
    for (int c = 0; c < 4; c++)
    begin
      wr(`IALB_IDX_LEAK_RATE, 8'hfc | 8'(c), 4'hf);
      rdr(`IALB_IDX_LEAK_RATE, rd);
      check(rd, 32'(c));
    end
  endtask : t_rate_codes

  task t_refused;
    wr(`IALB_IDX_LEAK_RATE, 8'h00, 4'he);
    rdr(`IALB_IDX_LEAK_RATE, rd);
    check(rd, 32'h3);
    wr(8'h10, 8'hff, 4'hf);
    rdr(8'h10, rd);
    check(rd, 32'h0);
    wr(`IALB_IDX_LEVEL, 8'h55, 4'hf);
    rdr(`IALB_IDX_LEVEL, rd);
    check(rd, 32'h0);
  endtask : t_refused

  task t_mask_status;
    wr(`IALB_IDX_MASK, 8'hff, 4'hf);
    rdr(`IALB_IDX_MASK, rd);
    check(rd, 32'h7);
    wr(`IALB_IDX_STATUS, 8'hff, 4'hf);
    rdr(`IALB_IDX_STATUS, rd);
    check(rd, 32'h0);
    check({31'h0, IRQ}, 32'h0);
  endtask : t_mask_status

  task t_fault_hold;
    wr(`IALB_IDX_LEAK_RATE, 8'h00, 4'hf);
    wait_tick();
    FAULT_IN <= 1'b1;
    wait_tick();
    wait_tick();
    repeat (8) @(posedge REF_CLK);
    FAULT_IN <= 1'b0;
    wait_tick();
    rdr(`IALB_IDX_LEVEL, rd);
    check(rd, 32'h3);
    wait_tick();
    rdr(`IALB_IDX_LEVEL, rd);
    check(rd, 32'h2);
    wr(`IALB_IDX_LEAK_RATE, 8'h01, 4'hf);
    wait_tick();
    rdr(`IALB_IDX_LEVEL, rd);
    check(rd, 32'h2);
    wait_tick();
    rdr(`IALB_IDX_LEVEL, rd);
    check(rd, 32'h1);
    wr(`IALB_IDX_LEAK_RATE, 8'h00, 4'hf);
    wait_tick();
    wait_tick();
    rdr(`IALB_IDX_LEVEL, rd);
    check(rd, 32'h0);
    rdr(`IALB_IDX_STATUS, rd);
    check(rd, 32'h7);
    check({31'h0, IRQ}, 32'h1);
    wr(`IALB_IDX_STATUS, 8'h07, 4'hf);
    rdr(`IALB_IDX_STATUS, rd);
    check(rd, 32'h0);
    check({31'h0, IRQ}, 32'h0);
  endtask : t_fault_hold

  task t_second_reset;
    wr(`IALB_IDX_LEAK_RATE, 8'h00, 4'h1);
    @(posedge REF_CLK);
    RESETN <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    RESETN <= 1'b1;
    rdr(`IALB_IDX_LEAK_RATE, rd);
    check(rd, {24'h0, `IALB_LEAK_RATE_RST});
    rdr(`IALB_IDX_MASK, rd);
    check(rd, 32'h0);
    rdr(`IALB_IDX_LEVEL, rd);
    check(rd, 32'h0);
    check({31'h0, IRQ}, 32'h0);
  endtask : t_second_reset

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge REF_CLK);
    RESETN <= 1'b1;
    t_reset_values();
    t_rate_codes();
    t_refused();
    t_mask_status();
    t_fault_hold();
    t_second_reset();
    conclude();
  end
endmodule : ialb_bench
